// ===== logic/psr_refresh_sched.sv
// Hidden refresh scheduler and access timing inside the pseudo-static RAM
// Functional notes
// - Back-to-back async accesses need no deselect
// - Long page select: intrapage reads use random
// - Burst ends on select high clock edge
// - Row crossing raises wait, schedules refresh
`timescale 1ns/10ps
`default_nettype none
module psr_refresh_sched #(
  parameter int COL_W    = psr_pkg::ROW_COL_W,
  parameter int ROW_OPEN = psr_pkg::ROW_OPEN_CYC
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // Memory bus pins
  input  wire psr_pkg::psr_bus_t             bus,
  input  wire psr_pkg::psr_mode_t            mode,
  input  wire logic                          burst_clk,
  input  wire logic [psr_pkg::DATA_W-1:0]    dq_in,
  output logic [psr_pkg::DATA_W-1:0]         dq_out,
  output logic                               dq_oe_n,
  output logic                               wait_o,
  // Array side
  input  wire logic [psr_pkg::DATA_W-1:0]    array_rdata,
  output psr_pkg::psr_evt_t                  evt,
  output logic [psr_pkg::ADDR_W-1:0]         array_addr,
  output logic [psr_pkg::DATA_W-1:0]         array_wdata,
  // Status
  output logic                               rd_valid,
  output logic                               ext_write,
  output logic                               page_slow,
  output logic                               refresh_overdue
);
  localparam int AW = psr_pkg::ADDR_W;
  localparam logic [3:0] AA_V  = 4'(psr_pkg::RANDOM_ACCESS_CYC);
  localparam logic [3:0] APA_V = 4'(psr_pkg::INTRAPAGE_ACCESS_CYC);

  typedef enum logic [1:0] {ST_STANDBY, ST_ACTIVE, ST_ROW_OPEN} psr_state_t;

  psr_state_t           st_reg, st_next;
  logic [AW-1:0]        addr_prev_reg, burst_addr_reg;
  logic [3:0]           acc_reg;
  logic                 ce_prev_reg, wr_prev_reg, clk_prev_reg;
  logic                 burst_act_reg, ext_wr_reg, ref_pend_reg, slow_reg, overdue_reg;
  logic [psr_pkg::DATA_W-1:0] wdata_reg, rdata_reg;
  psr_pkg::psr_evt_t    evt_reg;
  logic                 ce_over, addr_over, wp_over, hi_over, ref_tick, row_done;

  // Pin decode
  wire ce_act     = !bus.ce_n;
  wire wr_act     = ce_act && !bus.we_n;
  wire ce_fall    = ce_act && !ce_prev_reg;
  wire addr_chg   = ce_act && (bus.addr != addr_prev_reg);
  wire clk_rise   = burst_clk && !clk_prev_reg;
  wire is_burst   = (mode == psr_pkg::PSR_MODE_BURST);
  wire is_page    = (mode == psr_pkg::PSR_MODE_PAGE);
  wire wr_end     = wr_prev_reg && !wr_act;
  wire same_page  = (bus.addr[AW-1:psr_pkg::PAGE_W] == addr_prev_reg[AW-1:psr_pkg::PAGE_W]);
  wire row_wrap   = &burst_addr_reg[COL_W-1:0];
  wire row_enter  = (st_reg == ST_ACTIVE) && (st_next == ST_ROW_OPEN);
  wire burst_done = is_burst && clk_rise && !ce_act && burst_act_reg;
  wire ext_set    = wr_act && !is_burst && ce_over && addr_over;
  wire ext_ref_ok = ext_wr_reg && wp_over;

  // Select low, address stable, write pulse, deselect and refresh spans
  psr_span_timer #(.W(psr_pkg::TMR_W), .LIMIT(psr_pkg::MAX_SELECT_LOW_CYC)) u_ce_tmr (
    .mclk(mclk), .sys_rst(sys_rst), .run(ce_act), .clr(!ce_act),
    .count(), .reached(ce_over));
  psr_span_timer #(.W(psr_pkg::TMR_W), .LIMIT(psr_pkg::MAX_ADDRESS_VALID_CYC)) u_addr_tmr (
    .mclk(mclk), .sys_rst(sys_rst), .run(ce_act), .clr(addr_chg || !ce_act),
    .count(), .reached(addr_over));
  psr_span_timer #(.W(psr_pkg::TMR_W), .LIMIT(psr_pkg::WRITE_CYCLE_CYC)) u_wp_tmr (
    .mclk(mclk), .sys_rst(sys_rst), .run(wr_act), .clr(!wr_act),
    .count(), .reached(wp_over));
  psr_span_timer #(.W(psr_pkg::TMR_W), .LIMIT(psr_pkg::SELECT_HIGH_MIN_CYC)) u_hi_tmr (
    .mclk(mclk), .sys_rst(sys_rst), .run(!ce_act), .clr(ce_act),
    .count(), .reached(hi_over));
  // Tick cycle itself clears, so limit is one short of the window
  psr_span_timer #(.W(psr_pkg::TMR_W), .LIMIT(psr_pkg::REFRESH_WINDOW_CYC - 1)) u_ref_tmr (
    .mclk(mclk), .sys_rst(sys_rst), .run(1'b1), .clr(ref_tick),
    .count(), .reached(ref_tick));
  // Leave state on the last open cycle, giving exactly ROW_OPEN wait cycles
  psr_span_timer #(.W(psr_pkg::TMR_W), .LIMIT(ROW_OPEN - 1)) u_row_tmr (
    .mclk(mclk), .sys_rst(sys_rst), .run(st_reg == ST_ROW_OPEN),
    .clr(st_reg != ST_ROW_OPEN), .count(), .reached(row_done));

  // Refresh opportunities
  // deselect long enough
  wire opp_standby = !is_burst && hi_over;
  // page mode addresses give no chance
  wire opp_addr    = (mode == psr_pkg::PSR_MODE_ASYNC) && addr_chg && !wr_act;
  // stretched write pulse hides a refresh
  wire opp_extwr   = ext_ref_ok;
  wire opp_row     = row_enter;
  wire opp_burst   = burst_done;
  wire refresh_go  = ref_pend_reg && (opp_standby || opp_addr || opp_extwr || opp_row || opp_burst);
  // Set wins over clear so a tick is never lost
  wire ref_pend_next = ref_tick || (ref_pend_reg && !refresh_go);

  // Read latency selection
  // slow page falls back to random
  wire intrapage   = is_page && !slow_reg && same_page && !ce_fall;
  wire [3:0] lat   = intrapage ? APA_V : AA_V;
  wire slow_next   = ce_act && (slow_reg || (is_page && ce_over && bus.we_n));

  // State transitions
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_STANDBY: begin
        if (ce_act) st_next = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (!ce_act) begin
          st_next = ST_STANDBY;
        // crossing a row opens the next one
        end else if (is_burst && clk_rise && row_wrap && burst_act_reg) begin
          st_next = ST_ROW_OPEN;
        end
      end
      ST_ROW_OPEN: begin
        if (row_done) st_next = ce_act ? ST_ACTIVE : ST_STANDBY;
      end
      default: st_next = ST_STANDBY;
    endcase
  end

  // State, edge history and flags
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg       <= ST_STANDBY;
      ce_prev_reg  <= 1'b0;
      wr_prev_reg  <= 1'b0;
      clk_prev_reg <= 1'b0;
      ref_pend_reg <= 1'b0;
      slow_reg     <= 1'b0;
      overdue_reg  <= 1'b0;
      ext_wr_reg   <= 1'b0;
    end else begin
      st_reg       <= st_next;
      ce_prev_reg  <= ce_act;
      wr_prev_reg  <= wr_act;
      clk_prev_reg <= burst_clk;
      ref_pend_reg <= ref_pend_next;
      slow_reg     <= slow_next;
      overdue_reg  <= overdue_reg || (ref_tick && ref_pend_reg && !refresh_go);
      // long select and address stretch the write
      ext_wr_reg   <= wr_act && (ext_wr_reg || ext_set);
    end
  end

  // Burst tracking
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      burst_act_reg  <= 1'b0;
      burst_addr_reg <= '0;
    end else if (ce_fall && is_burst) begin
      burst_act_reg  <= 1'b1;
      burst_addr_reg <= bus.addr;
    // select high on a clock rise ends the burst
    end else if (burst_done) begin
      burst_act_reg  <= 1'b0;
    end else if (clk_rise && ce_act && burst_act_reg && st_reg == ST_ACTIVE) begin
      burst_addr_reg <= burst_addr_reg + 1'b1;
    end
  end

  // Address history, access counter and data paths
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_prev_reg <= '0;
      acc_reg       <= '0;
      wdata_reg     <= '0;
      rdata_reg     <= '0;
      evt_reg       <= '0;
    end else begin
      addr_prev_reg <= bus.addr;
      if (addr_chg || ce_fall) acc_reg <= lat;
      else if (acc_reg != 4'h0) acc_reg <= acc_reg - 4'h1;
      if (wr_act) wdata_reg <= dq_in;
      if (rd_valid) rdata_reg <= array_rdata;
      // each write commits without a deselect
      evt_reg <= '{refresh_go: refresh_go, array_wr: wr_end, burst_done: burst_done};
    end
  end

  // Outputs
  assign rd_valid        = ce_act && bus.we_n && (acc_reg == 4'h0) && !addr_chg && !ce_fall;
  assign dq_out          = rdata_reg;
  assign dq_oe_n         = !(ce_act && bus.we_n && !bus.oe_n && rd_valid);
  assign wait_o          = (st_reg == ST_ROW_OPEN);
  assign evt             = evt_reg;
  assign array_addr      = addr_prev_reg;
  assign array_wdata     = wdata_reg;
  assign ext_write       = ext_wr_reg;
  assign page_slow       = slow_reg;
  assign refresh_overdue = overdue_reg;

  // Checks
  sequence s_row_enter;
    (st_reg == ST_ACTIVE) ##1 (st_reg == ST_ROW_OPEN);
  endsequence
  sequence s_write_then_next;
    wr_act ##1 (!wr_act && ce_act);
  endsequence

  a_slow_page_lat: assert property (@(posedge mclk) disable iff (sys_rst)
    slow_reg && addr_chg |=> acc_reg == AA_V)
    else $error("slow page read did not use random access latency");
  a_slow_page_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    slow_reg && ce_act |=> slow_reg)
    else $error("slow page flag dropped while selected");
  a_row_wait_len: assert property (@(posedge mclk) disable iff (sys_rst)
    s_row_enter |-> wait_o[*3] ##1 !wait_o)
    else $error("wait not held for the row opening");
  a_row_refresh: assert property (@(posedge mclk) disable iff (sys_rst)
    row_enter && ref_pend_reg |-> refresh_go ##1 evt.refresh_go)
    else $error("row crossing did not schedule pending refresh");
  a_burst_end: assert property (@(posedge mclk) disable iff (sys_rst)
    is_burst && clk_rise && !ce_act && burst_act_reg |=> evt.burst_done && !burst_act_reg)
    else $error("burst not ended on select high clock rise");
  a_back_to_back: assert property (@(posedge mclk) disable iff (sys_rst)
    s_write_then_next |=> evt.array_wr)
    else $error("write without deselect was not committed");
  a_deselect_refresh: assert property (@(posedge mclk) disable iff (sys_rst)
    ref_pend_reg && !is_burst && $past(!ce_act) && !ce_act |-> refresh_go)
    else $error("deselect did not take pending refresh");
endmodule
`default_nettype wire

// ===== logic/psr_pkg.sv
// Shared constants and types for the pseudo-static RAM refresh scheduler
`default_nettype none
package psr_pkg;
  // Bus and clock
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 10;
  localparam int TMR_W  = 12;
  // Longest times, rounded down to cycles
  localparam int MAX_SELECT_LOW_TIME_US    = 4;
  localparam int MAX_SELECT_LOW_CYC        = MAX_SELECT_LOW_TIME_US * 1000 / CLK_NS;
  localparam int MAX_ADDRESS_VALID_TIME_US = 4;
  localparam int MAX_ADDRESS_VALID_CYC     = MAX_ADDRESS_VALID_TIME_US * 1000 / CLK_NS;
  localparam int REFRESH_WINDOW_US         = 4;
  localparam int REFRESH_WINDOW_CYC        = REFRESH_WINDOW_US * 1000 / CLK_NS;
  localparam int RANDOM_ACCESS_TIME_NS     = 70;
  localparam int RANDOM_ACCESS_CYC         = RANDOM_ACCESS_TIME_NS / CLK_NS;
  localparam int INTRAPAGE_ACCESS_TIME_NS  = 20;
  localparam int INTRAPAGE_ACCESS_CYC      = INTRAPAGE_ACCESS_TIME_NS / CLK_NS;
  // Least times, rounded up to cycles
  localparam int WRITE_CYCLE_TIME_NS       = 70;
  localparam int WRITE_CYCLE_CYC           = (WRITE_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int SELECT_HIGH_MIN_TIME_NS   = 5;
  localparam int SELECT_HIGH_MIN_CYC       = (SELECT_HIGH_MIN_TIME_NS + CLK_NS - 1) / CLK_NS;
  // Array geometry and row opening
  localparam int PAGE_W       = 4;
  localparam int ROW_COL_W    = 7;
  localparam int ROW_OPEN_CYC = 3;

  // Operating mode of the memory
  typedef enum logic [1:0] {
    PSR_MODE_ASYNC,
    PSR_MODE_PAGE,
    PSR_MODE_BURST
  } psr_mode_t;

  // Memory bus pins as seen by the device
  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
  } psr_bus_t;

  // One-cycle events towards the array
  typedef struct packed {
    logic refresh_go;
    logic array_wr;
    logic burst_done;
  } psr_evt_t;
endpackage
`default_nettype wire

// ===== logic/psr_span_timer.sv
// Saturating span timer with a reached flag
`timescale 1ns/10ps
`default_nettype none
module psr_span_timer #(
  parameter int W     = 12,
  parameter int LIMIT = 400
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Control
  input  wire logic         run,
  input  wire logic         clr,
  // Status
  output logic [W-1:0]      count,
  output logic              reached
);
  localparam logic [W-1:0] LIMIT_V = W'(LIMIT);

  // Reached once the span hits the limit
  assign reached = (count >= LIMIT_V);

  // Count up, hold at limit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (clr) begin
      count <= '0;
    end else if (run && !reached) begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/psr_ctl_model.sv
// Memory controller model driving the device pins
`timescale 1ns/10ps
`default_nettype none
module psr_ctl_model (
  // Clock
  input  wire logic                      mclk,
  // Memory bus pins
  output var psr_pkg::psr_bus_t          bus,
  output var psr_pkg::psr_mode_t         mode,
  output var logic                       burst_clk,
  output var logic [psr_pkg::DATA_W-1:0] dq_in
);
  // Idle bus at time zero
  initial begin
    bus = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
    mode = psr_pkg::PSR_MODE_ASYNC;
    burst_clk = 1'b0;
    dq_in = 16'h0000;
  end
  task automatic put(input logic ce_n, input logic we_n, input logic [21:0] a,
                     input logic [15:0] d = 16'h0000);
    @(negedge mclk);
    bus = '{ce_n: ce_n, we_n: we_n, oe_n: ~we_n, addr: a};
    dq_in = we_n ? ~dq_in : d; // Released data line never holds
  endtask
  task automatic hold(input int n);
    repeat (n) begin
      @(negedge mclk);
      if (bus.we_n) dq_in = ~dq_in;
    end
  endtask
  task automatic bclk(input logic v);
    @(negedge mclk);
    burst_clk = v;
  endtask
  task automatic set_mode(input psr_pkg::psr_mode_t m);
    @(negedge mclk);
    mode = m;
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the refresh scheduler
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int RFG = 0, AWR = 1, BDN = 2, EXT = 3, PSL = 4, RDV = 5;
  logic               mclk = 1'b0;
  logic               sys_rst = 1'b1;
  logic [15:0]        array_rdata = 16'hA5C3;
  psr_pkg::psr_bus_t  bus;
  psr_pkg::psr_mode_t mode;
  psr_pkg::psr_evt_t  evt;
  logic               burst_clk, dq_oe_n, wait_o, rd_valid, ext_write, page_slow;
  logic               refresh_overdue;
  logic [15:0]        dq_in, dq_out, array_wdata;
  logic [21:0]        array_addr;
  int                 errors = 0, samples_checked = 0, cyc = 0, wcnt = 0;
  wire logic [5:0]    mon = {rd_valid, page_slow, ext_write, evt.burst_done, evt.array_wr,
                             evt.refresh_go};
  // Clock
  always #(psr_pkg::CLK_NS / 2) mclk = ~mclk;
  // Controller and device
  psr_ctl_model i_ctl (.mclk(mclk), .bus(bus), .mode(mode), .burst_clk(burst_clk),
    .dq_in(dq_in));
  psr_refresh_sched i_dut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .mode(mode),
    .burst_clk(burst_clk), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .wait_o(wait_o), .array_rdata(array_rdata), .evt(evt), .array_addr(array_addr),
    .array_wdata(array_wdata), .rd_valid(rd_valid), .ext_write(ext_write),
    .page_slow(page_slow), .refresh_overdue(refresh_overdue));
  // Compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Cycles until a watched output is high, bounded
  task automatic wt(input int i, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (mon[i] !== 1'b1 && n < lim);
  endtask
  // Verdict
  task automatic end_sim();
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Cycle ceiling and wait length count
  always @(posedge mclk) begin
    cyc++;
    if (wait_o === 1'b1) wcnt++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  // Reads with select kept low between them
  task automatic t_read();
    int n;
    i_ctl.put(1'b0, 1'b1, 22'h00_0100);
    wt(RDV, 20, n);
    chk("read latency", psr_pkg::RANDOM_ACCESS_CYC + 1, n);
    i_ctl.put(1'b0, 1'b1, 22'h00_0280);
    array_rdata = 16'h3C5A;
    wt(RDV, 20, n);
    chk("next read latency", psr_pkg::RANDOM_ACCESS_CYC + 1, n);
    chk("dq_oe_n", 0, dq_oe_n);
    @(posedge mclk);
    #1;
    chk("dq_out", array_rdata, dq_out);
    i_ctl.put(1'b1, 1'b1, 22'h00_0280);
  endtask
  // Plain write then deselect
  task automatic t_write();
    int n;
    i_ctl.put(1'b0, 1'b0, 22'h00_0300, 16'h5A3C);
    i_ctl.hold(psr_pkg::WRITE_CYCLE_CYC);
    i_ctl.put(1'b1, 1'b1, 22'h00_0300);
    wt(AWR, 6, n);
    chk("array_wr delay", 1, n);
    chk("array_wdata", 16'h5A3C, array_wdata);
    chk("array_addr", 22'h00_0300, array_addr);
    chk("ext_write short", 0, ext_write);
  endtask
  // Long read then deselect lets the refresh run
  task automatic t_refresh();
    int n;
    i_ctl.put(1'b0, 1'b1, 22'h00_0400);
    i_ctl.hold(psr_pkg::REFRESH_WINDOW_CYC);
    i_ctl.put(1'b1, 1'b1, 22'h00_0400);
    wt(RFG, 4, n);
    chk("refresh_go delay", 2, n);
  endtask
  // Write after long select and steady address is extended
  task automatic t_ext();
    int n;
    i_ctl.put(1'b0, 1'b1, 22'h00_0400);
    i_ctl.hold(psr_pkg::MAX_SELECT_LOW_CYC + 2);
    i_ctl.put(1'b0, 1'b0, 22'h00_0400, 16'hC3A5);
    wt(EXT, 4, n);
    chk("ext_write", 1, ext_write);
    wt(RFG, 12, n);
    chk("refresh_go in write", 1, evt.refresh_go);
    i_ctl.put(1'b1, 1'b1, 22'h00_0400);
    wt(AWR, 6, n);
    chk("extended array_wdata", 16'hC3A5, array_wdata);
    chk("ext_write ended", 0, ext_write);
  endtask
  // Page reads slow down after a long select
  task automatic t_page();
    int n;
    i_ctl.set_mode(psr_pkg::PSR_MODE_PAGE);
    i_ctl.put(1'b0, 1'b1, 22'h01_2340);
    wt(RDV, 20, n);
    chk("page first read", psr_pkg::RANDOM_ACCESS_CYC + 1, n);
    i_ctl.put(1'b0, 1'b1, 22'h01_2341);
    wt(RDV, 20, n);
    chk("intrapage read", psr_pkg::INTRAPAGE_ACCESS_CYC + 1, n);
    i_ctl.hold(psr_pkg::MAX_SELECT_LOW_CYC);
    wt(PSL, 4, n);
    chk("page_slow", 1, page_slow);
    i_ctl.put(1'b0, 1'b1, 22'h01_2342);
    wt(RDV, 20, n);
    chk("slow intrapage read", psr_pkg::RANDOM_ACCESS_CYC + 1, n);
    i_ctl.put(1'b1, 1'b1, 22'h01_2342);
    i_ctl.hold(2);
    chk("page_slow cleared", 0, page_slow);
  endtask
  // Row crossing raises wait; select high on a clock edge ends the burst
  task automatic t_burst();
    int n;
    i_ctl.set_mode(psr_pkg::PSR_MODE_BURST);
    i_ctl.put(1'b0, 1'b1, 22'h00_057E);
    wcnt = 0;
    repeat (3) begin
      i_ctl.bclk(1'b1);
      i_ctl.bclk(1'b0);
    end
    i_ctl.hold(4);
    chk("wait_o cycles", psr_pkg::ROW_OPEN_CYC, wcnt);
    i_ctl.put(1'b1, 1'b1, 22'h00_057E);
    i_ctl.bclk(1'b1);
    wt(BDN, 4, n);
    chk("burst_done delay", 1, n);
    i_ctl.bclk(1'b0);
    chk("refresh_overdue", 0, refresh_overdue);
  endtask
  // Burst select held with no burst clock and no row crossing misses a window
  task automatic t_overdue();
    i_ctl.put(1'b0, 1'b1, 22'h00_0600);
    i_ctl.hold(2 * psr_pkg::REFRESH_WINDOW_CYC);
    chk("refresh_overdue set", 1, refresh_overdue);
    i_ctl.put(1'b1, 1'b1, 22'h00_0600);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge mclk);
    chk("outputs in reset", 0, {evt, wait_o, ext_write, page_slow, refresh_overdue});
    sys_rst = 1'b0;
    t_read();
    t_write();
    t_refresh();
    t_ext();
    t_page();
    t_burst();
    t_overdue();
    end_sim();
  end
endmodule
`default_nettype wire
